//--- dsop_pkg.sv
// constants, command codes and carriers for the device status and opc block
package dsop_pkg;
	// device status bit positions
	localparam int DS_A_PRES  = 1;
	localparam int DS_B_PRES  = 2;
	localparam int DS_A_ERR   = 3;
	localparam int DS_B_ERR   = 4;
	localparam int DS_A_REAR  = 5;
	localparam int DS_B_REAR  = 6;
	localparam int DS_C_PRES  = 7;
	localparam int DS_D_PRES  = 8;
	localparam int DS_EVT_LO  = 11;
	localparam int DS_EVT_HI  = 14;
	// positions that follow a condition, and event-only positions
	localparam logic [15:0] DS_COND_MASK = 16'h01FE;
	localparam logic [15:0] DS_EVT_MASK  = 16'h7800;
	// standard event status and status byte positions
	localparam int ESR_OPC_BIT = 0;
	localparam int STB_DEV_BIT = 0;
	localparam int STB_ESB_BIT = 5;
	localparam int STB_MSS_BIT = 6;
	localparam logic [7:0] SRE_MASK  = 8'hBF;
	localparam logic [7:0] OPC_ASCII = 8'h31;
	// reset values
	localparam logic [15:0] DS_ENABLE_RST = 16'h0000;
	localparam logic [15:0] DS_PTR_RST    = 16'h7FFF;
	localparam logic [15:0] DS_NTR_RST    = 16'h0000;

	// host-side operations decoded by the command parser
	typedef enum logic [3:0] {
		DSOP_NOP,
		DSOP_RD_COND,
		DSOP_RD_EVENT,
		DSOP_WR_ENABLE,
		DSOP_WR_PTR,
		DSOP_WR_NTR,
		DSOP_CLS,
		DSOP_WR_ESE,
		DSOP_WR_SRE,
		DSOP_RD_ESR,
		DSOP_OPC,
		DSOP_OPC_QUERY,
		DSOP_STB_QUERY,
		DSOP_DEV_CLEAR
	} dsop_op_t;

	typedef struct packed {
		logic        valid;
		dsop_op_t    op;
		logic [15:0] data;
	} dsop_cmd_t;

	// raw sensor pins, channels a..d in bits 0..3 of present, a..b in bits 0..1 of the others
	typedef struct packed {
		logic [3:0] present;
		logic [1:0] eeprom_fail;
		logic [1:0] front;
		logic [1:0] rear;
	} dsop_sense_t;
endpackage

//--- dsop_status.sv
// device status group, standard event status, status byte and opc logic
`timescale 1ns/100ps
`default_nettype none
module dsop_status
	import dsop_pkg::*;
(
	// clock and reset
	input  wire logic        clk,
	input  wire logic        arst_n,
	// sensor pins and event strobes
	input  wire dsop_sense_t sense,
	input  wire logic [3:0]  event_pulse,
	input  wire logic        ops_busy,
	// decoded host command
	input  wire dsop_cmd_t   cmd,
	// command answer
	output logic             resp_valid,
	output logic [15:0]      resp_data,
	// output queue toward the host link
	output logic             oq_valid,
	output logic [7:0]       oq_data,
	input  wire logic        oq_take,
	// service request
	output logic             srq
);
	logic        rst_meta;
	logic        rst_n;
	dsop_sense_t sense_meta;
	dsop_sense_t sense_sync;
	logic [15:0] cond;
	logic [15:0] cond_prev;
	logic [15:0] next_cond_prev;
	logic [15:0] evt;
	logic [15:0] next_evt;
	logic [15:0] ds_en;
	logic [15:0] next_ds_en;
	logic [15:0] ptr;
	logic [15:0] next_ptr;
	logic [15:0] ntr;
	logic [15:0] next_ntr;
	logic [7:0]  esr;
	logic [7:0]  next_esr;
	logic [7:0]  ese;
	logic [7:0]  next_ese;
	logic [7:0]  sre;
	logic [7:0]  next_sre;
	logic [7:0]  stb;
	logic        opc_pend;
	logic        next_opc_pend;
	logic        oqry_pend;
	logic        next_oqry_pend;
	logic        next_resp_valid;
	logic [15:0] next_resp_data;
	logic        next_oq_valid;
	logic [7:0]  next_oq_data;
	logic        next_srq;

	// reset release through two flops, assertion stays asynchronous
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			rst_meta <= 1'b0;
			rst_n    <= 1'b0;
		end else begin
			rst_meta <= 1'b1;
			rst_n    <= rst_meta;
		end
	end

	// sensor pins are asynchronous to clk: two flops before use
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			sense_meta <= '0;
			sense_sync <= '0;
		end else begin
			sense_meta <= sense;
			sense_sync <= sense_meta;
		end
	end

	// condition word from synchronised pins
	always_comb begin
		cond = 16'h0000;
		cond[DS_A_PRES] = sense_sync.present[0];
		cond[DS_B_PRES] = sense_sync.present[1];
		cond[DS_C_PRES] = sense_sync.present[2];
		cond[DS_D_PRES] = sense_sync.present[3];
		cond[DS_A_ERR] = sense_sync.eeprom_fail[0]
			| (sense_sync.front[0] & sense_sync.rear[0]);
		cond[DS_B_ERR] = sense_sync.eeprom_fail[1]
			| (sense_sync.front[1] & sense_sync.rear[1]);
		cond[DS_A_REAR] = sense_sync.rear[0];
		cond[DS_B_REAR] = sense_sync.rear[1];
	end

	// status byte: summaries only, nothing in it is stored or cleared
	always_comb begin
		stb = 8'h00;
		stb[STB_DEV_BIT] = |(evt & ds_en);
		stb[STB_ESB_BIT] = |(esr & ese);
		stb[STB_MSS_BIT] = |(stb & sre & SRE_MASK);
	end

	// next state for registers, answers and queue
	always_comb begin
		next_cond_prev  = cond;
		next_evt        = evt;
		next_ds_en      = ds_en;
		next_ptr        = ptr;
		next_ntr        = ntr;
		next_esr        = esr;
		next_ese        = ese;
		next_sre        = sre;
		next_opc_pend   = opc_pend;
		next_oqry_pend  = oqry_pend;
		next_resp_valid = 1'b0;
		next_resp_data  = 16'h0000;
		next_oq_valid   = oq_valid & ~oq_take;
		next_oq_data    = oq_data;

		// clears first, so that a same-cycle event set wins below
		if (cmd.valid) begin
			case (cmd.op)
				DSOP_RD_COND: begin
					next_resp_valid = 1'b1;
					next_resp_data  = cond;
				end
				// read returns latched bits then clears
				DSOP_RD_EVENT: begin
					next_resp_valid = 1'b1;
					next_resp_data  = evt;
					next_evt        = 16'h0000;
				end
				DSOP_WR_ENABLE: next_ds_en = cmd.data & (DS_COND_MASK | DS_EVT_MASK);
				DSOP_WR_PTR:    next_ptr = cmd.data & DS_COND_MASK;
				DSOP_WR_NTR:    next_ntr = cmd.data & DS_COND_MASK;
				// clear status also cancels a waiting opc command
				DSOP_CLS: begin
					next_evt      = 16'h0000;
					next_esr      = 8'h00;
					next_opc_pend = 1'b0;
				end
				DSOP_WR_ESE:    next_ese = cmd.data[7:0];
				DSOP_WR_SRE:    next_sre = cmd.data[7:0] & SRE_MASK;
				DSOP_RD_ESR: begin
					next_resp_valid = 1'b1;
					next_resp_data  = {8'h00, esr};
					next_esr        = 8'h00;
				end
				DSOP_OPC:       next_opc_pend = 1'b1;
				DSOP_OPC_QUERY: next_oqry_pend = 1'b1;
				// status byte read, no side effect
				DSOP_STB_QUERY: begin
					next_resp_valid = 1'b1;
					next_resp_data  = {8'h00, stb};
				end
				// device clear empties the output queue
				DSOP_DEV_CLEAR: begin
					next_oq_valid  = 1'b0;
					next_oqry_pend = 1'b0;
				end
				default: next_resp_valid = 1'b0;
			endcase
		end

		// filters act on condition positions only
		next_evt = next_evt
			| (ptr & cond & ~cond_prev & DS_COND_MASK)
			| (ntr & ~cond & cond_prev & DS_COND_MASK);
		next_evt[DS_EVT_HI:DS_EVT_LO] = next_evt[DS_EVT_HI:DS_EVT_LO]
			| event_pulse;
		// unused positions never hold a bit
		next_evt = next_evt & (DS_COND_MASK | DS_EVT_MASK);

		// completion of pending work sets esr opc bit
		if (opc_pend && !ops_busy) begin
			next_esr[ESR_OPC_BIT] = 1'b1;
			next_opc_pend         = 1'b0;
		end
		// queue ascii one once nothing is pending
		if (oqry_pend && !ops_busy && !(cmd.valid
			&& cmd.op == DSOP_DEV_CLEAR)) begin
			next_oq_valid  = 1'b1;
			next_oq_data   = OPC_ASCII;
			next_oqry_pend = 1'b0;
		end
		// request service while mss is set
		next_srq = stb[STB_MSS_BIT];
	end

	// register all state
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cond_prev  <= 16'h0000;
			evt        <= 16'h0000;
			ds_en      <= DS_ENABLE_RST;
			ptr        <= DS_PTR_RST & DS_COND_MASK;
			ntr        <= DS_NTR_RST;
			esr        <= 8'h00;
			ese        <= 8'h00;
			sre        <= 8'h00;
			opc_pend   <= 1'b0;
			oqry_pend  <= 1'b0;
			resp_valid <= 1'b0;
			resp_data  <= 16'h0000;
			oq_valid   <= 1'b0;
			oq_data    <= 8'h00;
			srq        <= 1'b0;
		end else begin
			cond_prev  <= next_cond_prev;
			evt        <= next_evt;
			ds_en      <= next_ds_en;
			ptr        <= next_ptr;
			ntr        <= next_ntr;
			esr        <= next_esr;
			ese        <= next_ese;
			sre        <= next_sre;
			opc_pend   <= next_opc_pend;
			oqry_pend  <= next_oqry_pend;
			resp_valid <= next_resp_valid;
			resp_data  <= next_resp_data;
			oq_valid   <= next_oq_valid;
			oq_data    <= next_oq_data;
			srq        <= next_srq;
		end
	end
endmodule
`default_nettype wire

//--- dsop_status_props.sv
// port assertions for the device status and opc block
`timescale 1ns/100ps
`default_nettype none
module dsop_status_props
	import dsop_pkg::*;
(
	// clock and reset
	input wire logic        clk,
	input wire logic        arst_n,
	// inputs
	input wire dsop_sense_t sense,
	input wire logic [3:0]  event_pulse,
	input wire logic        ops_busy,
	input wire dsop_cmd_t   cmd,
	input wire logic        oq_take,
	// outputs
	input wire logic        resp_valid,
	input wire logic [15:0] resp_data,
	input wire logic        oq_valid,
	input wire logic [7:0]  oq_data,
	input wire logic        srq
);
	default clocking @(posedge clk); endclocking
	default disable iff (!arst_n);
	// an event read with no new event arriving
	sequence s_rd_evt;
		cmd.valid && cmd.op == DSOP_RD_EVENT && event_pulse == 4'h0;
	endsequence
	a_read_answer: assert property (cmd.valid && cmd.op inside
		{DSOP_RD_COND, DSOP_RD_EVENT, DSOP_RD_ESR, DSOP_STB_QUERY}
		|=> resp_valid) else $error("read not answered");
	a_no_stray: assert property (resp_valid |-> $past(cmd.valid))
		else $error("answer without request");
	a_evt_clears: assert property (s_rd_evt ##1 s_rd_evt
		|=> resp_data[14:11] == 4'h0) else $error("event not cleared");
	a_unused_zero: assert property (resp_valid && $past(cmd.op)
		inside {DSOP_RD_COND, DSOP_RD_EVENT}
		|-> (resp_data & 16'h8601) == 16'h0000) else $error("unused set");
	a_evt_no_cond: assert property (resp_valid
		&& $past(cmd.op) == DSOP_RD_COND |-> resp_data[14:11] == 4'h0)
		else $error("event bit in condition");
	a_opc_ascii: assert property (oq_valid |-> oq_data == 8'h31)
		else $error("reply byte wrong");
	a_opc_idle: assert property ($rose(oq_valid) |-> !$past(ops_busy))
		else $error("reply while busy");
	a_clear_queue: assert property (cmd.valid
		&& cmd.op == DSOP_DEV_CLEAR |=> !oq_valid) else $error("queue kept");
endmodule
bind dsop_status dsop_status_props u_props (.clk(clk), .arst_n(arst_n),
	.sense(sense), .event_pulse(event_pulse), .ops_busy(ops_busy),
	.cmd(cmd), .oq_take(oq_take), .resp_valid(resp_valid),
	.resp_data(resp_data), .oq_valid(oq_valid), .oq_data(oq_data),
	.srq(srq));
`default_nettype wire

//--- dsop_host.sv
// host model that takes reply bytes from the output queue
`timescale 1ns/100ps
`default_nettype none
module dsop_host (
	// clock and queue handshake
	input  wire logic      clk,
	input  wire logic      oq_valid,
	input  wire logic [7:0] oq_data,
	output var logic       oq_take,
	// stall control and what was taken
	input  wire logic      slow,
	output var logic [7:0] got,
	output var int         n_got
);
	// host reads the reply
	// one pulse per byte; slow leaves the byte waiting
	initial begin
		oq_take = 1'b0;
		got = 8'h00;
		n_got = 0;
		forever begin
			@(negedge clk);
			oq_take = oq_valid && !oq_take && !slow;
			if (oq_take) begin
				got = oq_data;
				n_got++;
			end
		end
	end
endmodule
`default_nettype wire

//--- dsop_status_tb.sv
// self-checking bench for the device status and opc block
`timescale 1ns/100ps
`default_nettype none
module dsop_status_tb;
	import dsop_pkg::*;
	logic        clk, arst_n, ops_busy, oq_take, slow;
	logic        resp_valid, oq_valid, srq;
	logic [3:0]  event_pulse;
	logic [7:0]  oq_data, got;
	logic [15:0] resp_data, rd_val;
	dsop_sense_t sense;
	dsop_cmd_t   cmd;
	int          n_fail, num_checks, n_got;
	dsop_status dut (.clk(clk), .arst_n(arst_n), .sense(sense),
		.event_pulse(event_pulse), .ops_busy(ops_busy), .cmd(cmd),
		.resp_valid(resp_valid), .resp_data(resp_data),
		.oq_valid(oq_valid), .oq_data(oq_data), .oq_take(oq_take),
		.srq(srq));
	dsop_host host (.clk(clk), .oq_valid(oq_valid), .oq_data(oq_data),
		.oq_take(oq_take), .slow(slow), .got(got), .n_got(n_got));
	task automatic chk(string name, logic [15:0] exp, logic [15:0] seen);
		num_checks++;
		if (seen !== exp) begin
			$display("mismatch %s expected %h seen %h", name, exp, seen);
			n_fail++;
		end
	endtask
	// one-cycle command; the answer may land one or two edges later
	task automatic issue(dsop_op_t op, logic [15:0] d);
		cmd <= '{1'b1, op, d};
		rd_val = 16'hXXXX;
		@(negedge clk);
		cmd.valid <= 1'b0;
		repeat (2) begin
			if (resp_valid === 1'b1) rd_val = resp_data;
			@(negedge clk);
		end
	endtask
	task automatic rd(dsop_op_t op, logic [15:0] exp, string name);
		issue(op, 16'h0000);
		chk(name, exp, rd_val);
	endtask
	// pins pass a two-flop sync, so allow four cycles to settle
	task automatic pins(logic [3:0] p, logic [1:0] e, f, r, logic [15:0] x);
		sense <= '{p, e, f, r};
		repeat (4) @(negedge clk);
		rd(DSOP_RD_COND, x, "condition");
	endtask
	task automatic end_of_test;
		$display("checks %0d mismatches %0d", num_checks, n_fail);
		if (n_fail == 0 && num_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	// run needs about 100 cycles
	initial begin
		repeat (2000) @(posedge clk);
		n_fail++;
		end_of_test();
	end
	initial begin
		{arst_n, ops_busy, slow, event_pulse} = '0;
		sense = '0;
		cmd = '0;
		repeat (6) @(negedge clk);
		arst_n = 1'b1;
		repeat (3) @(negedge clk);
		pins(4'hF, 2'h0, 2'h2, 2'h1, 16'h01A6);
		pins(4'hF, 2'h2, 2'h3, 2'h1, 16'h01BE);
		pins(4'h5, 2'h1, 2'h0, 2'h2, 16'h00CA);
		pins(4'h0, 2'h0, 2'h0, 2'h0, 16'h0000);
		$display("condition test done");
		// event-only bits with both filters shut
		issue(DSOP_WR_PTR, 16'h0000);
		issue(DSOP_WR_NTR, 16'h0000);
		issue(DSOP_RD_EVENT, 16'h0000);
		event_pulse <= 4'hF;
		@(negedge clk);
		event_pulse <= 4'h0;
		rd(DSOP_RD_COND, 16'h0000, "condition");
		rd(DSOP_RD_EVENT, 16'h7800, "event");
		rd(DSOP_RD_EVENT, 16'h0000, "event");
		// two reads back to back: the second must find the bits gone
		event_pulse <= 4'h5;
		@(negedge clk);
		event_pulse <= 4'h0;
		cmd <= '{1'b1, DSOP_RD_EVENT, 16'h0000};
		@(negedge clk);
		chk("event", 16'h2800, resp_data);
		@(negedge clk);
		cmd.valid <= 1'b0;
		chk("event", 16'h0000, resp_data);
		// let an edge pass before the next command is driven
		@(negedge clk);
		$display("event test done");
		issue(DSOP_DEV_CLEAR, 16'h0000);
		issue(DSOP_CLS, 16'h0000);
		issue(DSOP_WR_ESE, 16'h0001);
		issue(DSOP_WR_SRE, 16'h0020);
		ops_busy <= 1'b1;
		issue(DSOP_OPC, 16'h0000);
		rd(DSOP_STB_QUERY, 16'h0000, "status byte");
		ops_busy <= 1'b0;
		repeat (4) @(negedge clk);
		chk("srq", 16'h0001, 16'(srq));
		rd(DSOP_STB_QUERY, 16'h0060, "status byte");
		rd(DSOP_RD_ESR, 16'h0001, "esr");
		$display("opc test done");
		slow <= 1'b1;
		ops_busy <= 1'b1;
		issue(DSOP_OPC_QUERY, 16'h0000);
		chk("oq_valid", 16'h0000, 16'(oq_valid));
		ops_busy <= 1'b0;
		repeat (3) @(negedge clk);
		chk("queue", 16'h0131, {7'h00, oq_valid, oq_data});
		issue(DSOP_DEV_CLEAR, 16'h0000);
		chk("oq_valid", 16'h0000, 16'(oq_valid));
		slow <= 1'b0;
		issue(DSOP_OPC_QUERY, 16'h0000);
		repeat (3) @(negedge clk);
		chk("reply", 16'h3101, {got, 8'(n_got)});
		$display("query test done");
		end_of_test();
	end
endmodule
`default_nettype wire
